/* File: logic/fru_pkg.sv */
// fru_pkg: opcodes, widths and reset values for the file register unary unit
// assumes: one clock domain, no software-visible registers
package fru_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int NUM_REGS = 32;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic NULL_FLAG_RESET = 1'b0;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_CLEAR     = 3'b001,
    OP_COMPL     = 3'b010,
    OP_DEC       = 3'b011,
    OP_INC       = 3'b100,
    OP_DEC_SKIP  = 3'b101,
    OP_INC_SKIP  = 3'b110
  } fru_op_t;

  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_NOP  = 1'b1
  } fru_state_t;
endpackage

/* File: logic/fru_alu.sv */
// fru_alu: combinational result and flag decisions for one unary operation
// assumes: operand already read from the addressed file register
`timescale 1ns/10ps
module fru_alu (
  input  wire fru_pkg::fru_op_t op_in,
  input  wire logic [7:0]       operand_in,
  output logic [7:0]            result_out,
  output logic                  null_out,
  output logic                  flag_upd_out,
  output logic                  skip_out
);
  import fru_pkg::*;

  always_comb begin
    result_out = operand_in;
    flag_upd_out = 1'b0;
    skip_out = 1'b0;
    case (op_in)
      OP_CLEAR: begin
        result_out = ZERO_BYTE;
        flag_upd_out = 1'b1;
      end
      OP_COMPL: begin
        result_out = ~operand_in;
        flag_upd_out = 1'b1;
      end
      OP_DEC: begin
        result_out = operand_in - ONE_BYTE;
        flag_upd_out = 1'b1;
      end
      OP_INC: begin
        result_out = operand_in + ONE_BYTE;
        flag_upd_out = 1'b1;
      end
      OP_DEC_SKIP: begin
        result_out = operand_in - ONE_BYTE;
      end
      OP_INC_SKIP: begin
        result_out = operand_in + ONE_BYTE;
      end
      default: begin
        result_out = operand_in;
      end
    endcase
    null_out = (result_out == ZERO_BYTE);
    // flags untouched on skip variants, only the skip decision uses zero
    skip_out = ((op_in == OP_DEC_SKIP) || (op_in == OP_INC_SKIP)) && null_out;
  end
endmodule

/* File: logic/fru_core.sv */
// fru_core: executes six single-operand file register instructions
// assumes: one instruction offered per clock on the instruction clock
// Contract
// - clear writes zero to file, sets null flag
// - complement inverts operand, updates only null flag
// - decrement subtracts one, updates only null flag
// - increment adds one, updates only null flag
// - destination bit 0 accumulator, 1 file register, except clear, which always writes the file register
// - decrement-skip keeps flags, skips on zero result
// - increment-skip keeps flags, skips on zero result
// - skip drops prefetched instruction, runs no-operation
`timescale 1ns/10ps
module fru_core (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             instr_valid_in,
  input  wire fru_pkg::fru_op_t op_in,
  input  wire logic [4:0]       file_addr_in,
  input  wire logic             dest_in,
  output logic [7:0]            acc_out,
  output logic                  null_flag_out,
  output logic                  busy_out,
  output logic                  discard_out,
  output logic                  done_out,
  output logic [7:0]            file_rd_data_out
);
  import fru_pkg::*;

  typedef struct packed {
    fru_state_t  state;
    logic [7:0]  acc;
    logic        null_flag;
    logic        discard;
    logic        done;
    logic [7:0]  rd_data;
  } fru_ctl_t;

  fru_ctl_t   ctl_reg;
  fru_ctl_t   ctl_next;
  // file array kept outside the struct: 32 bytes, written one entry per cycle
  logic [7:0] file_reg [NUM_REGS];
  logic [7:0] file_wdata;
  logic       file_we;
  logic [7:0] operand;
  logic [7:0] alu_result;
  logic       alu_null;
  logic       alu_flag_upd;
  logic       alu_skip;
  logic       accept;

  assign operand = file_reg[file_addr_in];            // any of 0..31
  assign accept = instr_valid_in && (ctl_reg.state == ST_EXEC);

  fru_alu u_alu (
    .op_in        (op_in),
    .operand_in   (operand),
    .result_out   (alu_result),
    .null_out     (alu_null),
    .flag_upd_out (alu_flag_upd),
    .skip_out     (alu_skip)
  );

  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.discard = 1'b0;
    ctl_next.done = 1'b0;
    ctl_next.rd_data = operand;
    file_we = 1'b0;
    file_wdata = alu_result;
    case (ctl_reg.state)
      ST_EXEC: begin
        if (accept && (op_in != OP_NONE)) begin
          if ((op_in == OP_CLEAR) || (dest_in == DEST_FILE)) begin
            file_we = 1'b1;
          end else begin
            ctl_next.acc = alu_result;
          end
          if (alu_flag_upd) begin
            ctl_next.null_flag = alu_null;
          end
          if (alu_skip) begin
            ctl_next.state = ST_NOP;
            ctl_next.discard = 1'b1;
          end else begin
            ctl_next.done = 1'b1;
          end
        end
      end
      ST_NOP: begin
        // no-operation slot replacing the dropped fetch
        ctl_next.state = ST_EXEC;
        ctl_next.done = 1'b1;
      end
      default: begin
        ctl_next.state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_reg.state <= ST_EXEC;
      ctl_reg.acc <= ACC_RESET;
      ctl_reg.null_flag <= NULL_FLAG_RESET;
      ctl_reg.discard <= 1'b0;
      ctl_reg.done <= 1'b0;
      ctl_reg.rd_data <= FILE_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_file
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          file_reg[gi] <= FILE_RESET;
        end else if (file_we && (file_addr_in == 5'(gi))) begin
          file_reg[gi] <= file_wdata;
        end
      end
    end
  endgenerate

  assign acc_out = ctl_reg.acc;
  assign null_flag_out = ctl_reg.null_flag;
  assign busy_out = (ctl_reg.state == ST_NOP);
  assign discard_out = ctl_reg.discard;
  assign done_out = ctl_reg.done;
  assign file_rd_data_out = ctl_reg.rd_data;
endmodule

/* File: verif/fru_core_props.sv */
// fru_core_props: port checks for the unary unit
// assumes: bound into fru_core, one clock domain
`timescale 1ns/10ps
module fru_core_props (
  input logic             clk_in,
  input logic             rst_in,
  input logic             instr_valid_in,
  input fru_pkg::fru_op_t op_in,
  input logic             dest_in,
  input logic [7:0]       acc_out,
  input logic             null_flag_out,
  input logic             busy_out,
  input logic             discard_out,
  input logic             done_out
);
  import fru_pkg::*;
  wire tk = instr_valid_in && op_in != OP_NONE && !busy_out;
  wire sk = op_in == OP_DEC_SKIP || op_in == OP_INC_SKIP;
  wire zf = op_in == OP_COMPL || op_in == OP_DEC || op_in == OP_INC;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  clr_null_a: assert property (tk && op_in == OP_CLEAR |=> null_flag_out)
    else $error("clear flag");
  null_calc_a: assert property (tk && zf && !dest_in |=> null_flag_out == ~|acc_out)
    else $error("null flag");
  acc_keep_a: assert property (tk && dest_in |=> $stable(acc_out))
    else $error("acc written");
  skip_flag_a: assert property (tk && sk |=> $stable(null_flag_out))
    else $error("skip flag");
  one_cyc_a: assert property (tk && !sk |=> done_out && !busy_out && !discard_out)
    else $error("one cycle");
  drop_busy_a: assert property (discard_out |-> busy_out)
    else $error("discard busy");
  nop_end_a: assert property (discard_out |=> done_out && !busy_out)
    else $error("nop end");
  busy_idle_a: assert property (busy_out |-> !done_out)
    else $error("busy done");
  cover property (discard_out);
  cover property (tk && op_in == OP_CLEAR);
  cover property (tk && sk && !dest_in);
endmodule
bind fru_core fru_core_props u_props (.clk_in(clk_in), .rst_in(rst_in),
  .instr_valid_in(instr_valid_in), .op_in(op_in), .dest_in(dest_in), .acc_out(acc_out),
  .null_flag_out(null_flag_out), .busy_out(busy_out), .discard_out(discard_out),
  .done_out(done_out));

/* File: verif/fru_core_tb_top.sv */
// fru_core_tb_top: directed checks of the unary unit
// assumes: checker bound in, file registers reset to 00
`timescale 1ns/10ps
module fru_core_tb_top;
  import fru_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       v      = 1'b0;
  fru_op_t    op     = OP_NONE;
  logic [4:0] fa     = 5'h00;
  logic       d      = 1'b0;
  logic [7:0] acc, rd;
  logic       nf, bsy, dc, dn;
  int         err_total = 0;
  int         n_compared = 0;
  always #50 clk_in = ~clk_in;
  fru_core dut (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(v), .op_in(op),
    .file_addr_in(fa), .dest_in(d), .acc_out(acc), .null_flag_out(nf), .busy_out(bsy),
    .discard_out(dc), .done_out(dn), .file_rd_data_out(rd));
  function logic [15:0] st();
    return {acc, 4'h0, dn, dc, bsy, nf};
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t %h %h", $time, g, e);
    end
  endtask
  task run(input fru_op_t o, input logic [4:0] a, input logic dd);
    @(posedge clk_in);
    #10;
    v = 1'b1;
    op = o;
    fa = a;
    d = dd;
    @(posedge clk_in);
    #10;
    v = 1'b0;
  endtask
  // read back lags one edge: registered copy of the addressed byte; task waits two edges
  task rdchk(input logic [4:0] a, input logic [7:0] e);
    fa = a;
    repeat (2) @(posedge clk_in);
    #10;
    chk({8'h00, rd}, {8'h00, e});
  endtask
  task t_arith;
    run(OP_DEC, 5'h03, DEST_FILE);
    chk(st(), 16'h0008);
    rdchk(5'h03, 8'hFF);
    run(OP_COMPL, 5'h03, DEST_ACC);
    chk(st(), 16'h0009);
    run(OP_INC, 5'h03, DEST_ACC);
    chk(st(), 16'h0009);
    run(OP_DEC, 5'h03, DEST_ACC);
    chk(st(), 16'hFE08);
    rdchk(5'h03, 8'hFF);
  endtask
  task t_skip;
    run(OP_INC_SKIP, 5'h03, DEST_FILE);
    chk(st(), 16'hFE06);
    // offer an increment in the dropped slot: it must be ignored
    v = 1'b1;
    op = OP_INC;
    @(posedge clk_in);
    #10;
    v = 1'b0;
    chk(st(), 16'hFE08);
    rdchk(5'h03, 8'h00);
    run(OP_DEC_SKIP, 5'h05, DEST_ACC);
    chk(st(), 16'hFF08);
    run(OP_INC, 5'h03, DEST_FILE);
    run(OP_DEC_SKIP, 5'h03, DEST_ACC);
    chk(st(), 16'h0006);
  endtask
  task t_clear;
    run(OP_INC, 5'h1F, DEST_FILE);
    run(OP_COMPL, 5'h1F, DEST_ACC);
    chk(st(), 16'hFE08);
    // nonzero accumulator shows that clear leaves it alone
    run(OP_CLEAR, 5'h1F, DEST_ACC);
    chk(st(), 16'hFE09);
    rdchk(5'h1F, 8'h00);
  endtask
  task stop_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    #10;
    rst_in = 1'b0;
    t_arith();
    t_skip();
    t_clear();
    stop_test();
  end
  initial begin
    #50000;
    err_total++;
    stop_test();
  end
endmodule
